// *** rtl/lmdp_pkg.sv ***
// constants and types for the load module data path
package lmdp_pkg;
    // buffer geometry: two kilobytes per direction, byte wide
    localparam int          FIFO_DEPTH   = 2048;
    localparam int          PTR_W        = 11;
    localparam int          CNT_W        = 12;
    localparam int          DATA_W       = 8;
    localparam int          CRC_W        = 16;
    localparam logic [15:0] CRC_POLY     = 16'h1021;
    localparam logic [15:0] CRC_INIT     = 16'hFFFF;
    // indicator flash half period
    localparam int          CLK_HZ       = 40_000_000;
    localparam int          FLASH_MS     = 250;
    localparam int          FLASH_CYC    = CLK_HZ / 1000 * FLASH_MS;
    localparam int          FLASH_W      = 24;
    // disk states
    typedef enum logic [2:0] {
        LMDP_DISK_STOP  = 3'b001,
        LMDP_DISK_SPIN  = 3'b010,
        LMDP_DISK_SPEED = 3'b100
    } lmdp_disk_t;
    // error flag bit positions
    localparam int          ERR_FIFO_TX  = 0;
    localparam int          ERR_FIFO_RX  = 1;
    localparam int          ERR_SCSI     = 2;
    localparam int          ERR_LINK     = 3;
    localparam int          ERR_W        = 4;
endpackage

// *** rtl/lmdp_data_path.sv ***
// load module data path: fifo banks, parity, link check, isolator, power and indicator
`timescale 1ns/1ps
// Function
// - two kilobyte buffer for each direction between link end and scsi end.
// - fifo words carry parity written in, checked on read out.
// - scsi bytes driven get parity, received bytes are checked.
// - link data gets a crc appended; received crc is verified.
// - link and scsi sides move data by dma without the processor.
// - processor bus is cut from transfer bus during scsi dma.
// - otherwise processor reaches fifo banks and scsi registers.
// - isolation selected by control bit and readable as status.
// - processor test port writes and reads fifos at the link side.
// - converter enable only with switch on and software control on.
// - converter drops when control is off and switch is off.
// - indicator steady at speed, flashes spinning, dark when stopped.
module lmdp_data_path (
    // clock and reset
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_sys_rst,
    // link side: tx bank is link to scsi, rx bank is scsi to link
    input  wire logic                          i_link_valid,
    input  wire logic [lmdp_pkg::DATA_W-1:0]   i_link_data,
    input  wire logic                          i_link_last,
    input  wire logic [lmdp_pkg::CRC_W-1:0]    i_link_crc,
    output logic                               o_link_ready,
    output logic                               o_link_valid,
    output logic [lmdp_pkg::DATA_W-1:0]        o_link_data,
    output logic                               o_link_last,
    output logic [lmdp_pkg::CRC_W-1:0]         o_link_crc,
    input  wire logic                          i_link_rd,
    // scsi side dma, bytes with odd parity
    input  wire logic                          i_scsi_dma,
    input  wire logic                          i_scsi_rd,
    output logic                               o_scsi_valid,
    output logic [lmdp_pkg::DATA_W-1:0]        o_scsi_data,
    output logic                               o_scsi_par,
    input  wire logic                          i_scsi_wr,
    input  wire logic [lmdp_pkg::DATA_W-1:0]   i_scsi_data,
    input  wire logic                          i_scsi_par,
    // processor control
    input  wire logic                          i_cpu_isolate,
    input  wire logic                          i_cpu_test,
    input  wire logic                          i_cpu_wr,
    input  wire logic                          i_cpu_rd,
    input  wire logic [lmdp_pkg::DATA_W-1:0]   i_cpu_data,
    input  wire logic [lmdp_pkg::ERR_W-1:0]    i_err_clr,
    output logic                               o_cpu_valid,
    output logic [lmdp_pkg::DATA_W-1:0]        o_cpu_data,
    output logic                               o_bus_isolated,
    output logic                               o_cpu_bus_en,
    output logic [lmdp_pkg::ERR_W-1:0]         o_err,
    output logic                               o_tx_empty,
    output logic                               o_rx_full,
    // power and indicator
    input  wire logic                          i_pwr_switch,
    input  wire logic                          i_pwr_ctrl,
    input  wire logic [2:0]                    i_disk_state,
    output logic                               o_conv_en,
    output logic                               o_led
);
    localparam int PW = lmdp_pkg::PTR_W;
    localparam int CW = lmdp_pkg::CNT_W;
    localparam int DW = lmdp_pkg::DATA_W;
    localparam int KW = lmdp_pkg::CRC_W;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0][PW-1:0] wp;
        logic [1:0][PW-1:0] rp;
        logic [1:0][CW-1:0] cnt;
        logic [KW-1:0]      crc_in;
        logic [KW-1:0]      crc_out;
        logic [2:0]         sw_sync;
        logic               link_valid;
        logic [DW-1:0]      link_data;
        logic               link_last;
        logic [KW-1:0]      link_crc;
        logic               scsi_valid;
        logic [DW-1:0]      scsi_data;
        logic               scsi_par;
        logic               cpu_valid;
        logic [DW-1:0]      cpu_data;
        logic               isolated;
        logic               cpu_bus_en;
        logic [lmdp_pkg::ERR_W-1:0] err;
        logic               link_ready;
        logic               tx_empty;
        logic               rx_full;
        logic               conv_en;
        logic               led;
        logic [lmdp_pkg::FLASH_W-1:0] flash_cnt;
        logic               flash;
    } lmdp_state_t;

    lmdp_state_t st;
    lmdp_state_t next_st;

    // head word of each bank with its parity bit; bank 0 tx, bank 1 rx
    logic [DW:0] head [2];

    // crc step over one byte
    function automatic logic [KW-1:0] lmdp_crc(input logic [KW-1:0] c,
                                               input logic [DW-1:0] d);
        logic [KW-1:0] r;
        r = c;
        for (int i = DW - 1; i >= 0; i--) begin
            if (r[KW-1] ^ d[i]) begin
                r = {r[KW-2:0], 1'b0} ^ lmdp_pkg::CRC_POLY;
            end else begin
                r = {r[KW-2:0], 1'b0};
            end
        end
        return r;
    endfunction

    // bank strobes: processor test port replaces link dma at link end
    logic         test_mode;
    logic [1:0]   wr_en;
    logic [1:0]   rd_en;
    logic [DW:0]  wr_word [2];
    logic         cpu_link_wr;
    logic         cpu_link_rd;
    logic         link_wr;
    logic         link_rd;
    assign test_mode   = i_cpu_test && !i_scsi_dma;
    assign cpu_link_wr = test_mode && i_cpu_wr;
    assign cpu_link_rd = test_mode && i_cpu_rd;
    assign link_wr     = !test_mode && i_link_valid;
    assign link_rd     = !test_mode && i_link_rd;
    assign wr_en[0]    = (link_wr || cpu_link_wr) && st.cnt[0] != CW'(lmdp_pkg::FIFO_DEPTH);
    assign wr_en[1]    = i_scsi_wr && i_scsi_dma && st.cnt[1] != CW'(lmdp_pkg::FIFO_DEPTH);
    assign rd_en[0]    = i_scsi_rd && i_scsi_dma && st.cnt[0] != '0;
    assign rd_en[1]    = (link_rd || cpu_link_rd) && st.cnt[1] != '0;
    assign wr_word[0]  = test_mode ? {~^i_cpu_data, i_cpu_data}
                                   : {~^i_link_data, i_link_data};
    assign wr_word[1]  = {~^i_scsi_data, i_scsi_data};

    // ------------------------------------------------------------
    // fifo banks, one per direction
    // ------------------------------------------------------------
    for (genvar b = 0; b < 2; b++) begin : g_bank
        // storage, bit DW holds parity; each bank owns its own array
        logic [DW:0] mem [lmdp_pkg::FIFO_DEPTH];
        // storage write
        always_ff @(posedge i_sys_clk) begin
            if (wr_en[b]) begin
                mem[st.wp[b]] <= wr_word[b];
            end
        end
        // read data is taken at the current read pointer, so look through
        assign head[b] = mem[st.rp[b]];
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        for (int b = 0; b < 2; b++) begin
            if (wr_en[b]) begin
                next_st.wp[b] = st.wp[b] + PW'(1);
            end
            if (rd_en[b]) begin
                next_st.rp[b] = st.rp[b] + PW'(1);
            end
            next_st.cnt[b] = st.cnt[b] + CW'(wr_en[b]) - CW'(rd_en[b]);
        end
        // scsi side output, parity regenerated from stored byte
        next_st.scsi_valid = rd_en[0];
        if (rd_en[0]) begin
            next_st.scsi_data = head[0][DW-1:0];
            next_st.scsi_par  = ~^head[0][DW-1:0];
        end
        // link side output with running crc; cpu test read
        next_st.link_valid = rd_en[1] && !test_mode;
        next_st.link_last  = rd_en[1] && !test_mode && st.cnt[1] == CW'(1);
        next_st.cpu_valid  = rd_en[1] && test_mode;
        if (rd_en[1]) begin
            next_st.link_data = head[1][DW-1:0];
            next_st.cpu_data  = head[1][DW-1:0];
            if (!test_mode) begin
                next_st.crc_out = lmdp_crc(st.crc_out, head[1][DW-1:0]);
                if (st.cnt[1] == CW'(1)) begin
                    next_st.link_crc = lmdp_crc(st.crc_out, head[1][DW-1:0]);
                    next_st.crc_out  = lmdp_pkg::CRC_INIT;
                end
            end
        end
        // error flags, set wins over clear
        next_st.err = st.err & ~i_err_clr;
        if (rd_en[0] && ^head[0] != 1'b1) begin
            next_st.err[lmdp_pkg::ERR_FIFO_TX] = 1'b1;
        end
        if (rd_en[1] && ^head[1] != 1'b1) begin
            next_st.err[lmdp_pkg::ERR_FIFO_RX] = 1'b1;
        end
        if (wr_en[1] && ^{i_scsi_par, i_scsi_data} != 1'b1) begin
            next_st.err[lmdp_pkg::ERR_SCSI] = 1'b1;
        end
        // link crc check on incoming frame
        if (link_wr) begin
            next_st.crc_in = lmdp_crc(st.crc_in, i_link_data);
            if (i_link_last) begin
                next_st.crc_in = lmdp_pkg::CRC_INIT;
                if (lmdp_crc(st.crc_in, i_link_data) != i_link_crc) begin
                    next_st.err[lmdp_pkg::ERR_LINK] = 1'b1;
                end
            end
        end
        // isolator: cut during scsi dma or when software asks
        next_st.isolated   = i_scsi_dma || i_cpu_isolate;
        next_st.cpu_bus_en = !(i_scsi_dma || i_cpu_isolate);
        next_st.link_ready = !test_mode && next_st.cnt[0] != CW'(lmdp_pkg::FIFO_DEPTH);
        next_st.tx_empty   = next_st.cnt[0] == '0;
        next_st.rx_full    = next_st.cnt[1] == CW'(lmdp_pkg::FIFO_DEPTH);
        // switch sync; on needs switch and control, off needs both released,
        // so an active control blocks power-down from the switch alone
        next_st.sw_sync = {st.sw_sync[1:0], i_pwr_switch};
        if (st.sw_sync[2] == st.sw_sync[1]) begin
            if (st.sw_sync[1] && i_pwr_ctrl) begin
                next_st.conv_en = 1'b1;
            end else if (!st.sw_sync[1] && !i_pwr_ctrl) begin
                next_st.conv_en = 1'b0;
            end
        end
        // indicator flash timer
        if (st.flash_cnt == lmdp_pkg::FLASH_W'(lmdp_pkg::FLASH_CYC - 1)) begin
            next_st.flash_cnt = '0;
            next_st.flash     = !st.flash;
        end else begin
            next_st.flash_cnt = st.flash_cnt + lmdp_pkg::FLASH_W'(1);
        end
        case (i_disk_state)
            lmdp_pkg::LMDP_DISK_SPEED: next_st.led = 1'b1;
            lmdp_pkg::LMDP_DISK_SPIN:  next_st.led = st.flash;
            lmdp_pkg::LMDP_DISK_STOP:  next_st.led = 1'b0;
            default:                   next_st.led = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st            <= '0;
            st.crc_in     <= lmdp_pkg::CRC_INIT;
            st.crc_out    <= lmdp_pkg::CRC_INIT;
            st.isolated   <= 1'b1;
            st.link_ready <= 1'b1;
            st.tx_empty   <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign o_link_ready   = st.link_ready;
    assign o_link_valid   = st.link_valid;
    assign o_link_data    = st.link_data;
    assign o_link_last    = st.link_last;
    assign o_link_crc     = st.link_crc;
    assign o_scsi_valid   = st.scsi_valid;
    assign o_scsi_data    = st.scsi_data;
    assign o_scsi_par     = st.scsi_par;
    assign o_cpu_valid    = st.cpu_valid;
    assign o_cpu_data     = st.cpu_data;
    assign o_bus_isolated = st.isolated;
    assign o_cpu_bus_en   = st.cpu_bus_en;
    assign o_err          = st.err;
    assign o_tx_empty     = st.tx_empty;
    assign o_rx_full      = st.rx_full;
    assign o_conv_en      = st.conv_en;
    assign o_led          = st.led;
endmodule

// *** testbench/lmdp_data_path_sva.sv ***
// port assertions for the load module data path
`timescale 1ns/1ps
module lmdp_data_path_chk (
    // clock and reset
    input wire logic       i_sys_clk,
    input wire logic       i_sys_rst,
    // watched inputs
    input wire logic       i_scsi_dma,
    input wire logic       i_cpu_isolate,
    input wire logic [3:0] i_err_clr,
    input wire logic       i_pwr_switch,
    input wire logic       i_pwr_ctrl,
    input wire logic [2:0] i_disk_state,
    // watched outputs
    input wire logic       o_scsi_valid,
    input wire logic [7:0] o_scsi_data,
    input wire logic       o_scsi_par,
    input wire logic       o_bus_isolated,
    input wire logic       o_cpu_bus_en,
    input wire logic [3:0] o_err,
    input wire logic       o_conv_en,
    input wire logic       o_led
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // isolation and processor bus
    property p_iso_dma; i_scsi_dma |=> o_bus_isolated; endproperty
    a_iso_dma: assert property (p_iso_dma) else $error("bus joined in dma");
    property p_iso_free; !i_scsi_dma && !i_cpu_isolate |=> !o_bus_isolated; endproperty
    a_iso_free: assert property (p_iso_free) else $error("bus cut while idle");
    property p_iso_sw; i_cpu_isolate |=> o_bus_isolated && !o_cpu_bus_en; endproperty
    a_iso_sw: assert property (p_iso_sw) else $error("software isolation lost");
    // converter enable
    property p_conv_ctrl; !o_conv_en && !i_pwr_ctrl |=> !o_conv_en; endproperty
    a_conv_ctrl: assert property (p_conv_ctrl) else $error("converter on without ctrl");
    property p_conv_sw; (!i_pwr_switch [*4]) ##0 !i_pwr_ctrl |=> !o_conv_en; endproperty
    a_conv_sw: assert property (p_conv_sw) else $error("converter left on");
    property p_conv_hold; o_conv_en && i_pwr_ctrl |=> o_conv_en; endproperty
    a_conv_hold: assert property (p_conv_hold) else $error("converter dropped");
    // odd parity on scsi bytes
    property p_scsi_par; o_scsi_valid |-> ^{o_scsi_data, o_scsi_par}; endproperty
    a_scsi_par: assert property (p_scsi_par) else $error("bad scsi parity out");
    // error flags stay until cleared
    property p_err_hold; |(o_err & ~i_err_clr) |=> (($past(o_err & ~i_err_clr) & ~o_err) == 4'h0);
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error flag dropped");
    // indicator steady at speed
    property p_led_speed; (i_disk_state == 3'h4) [*2] |-> o_led; endproperty
    a_led_speed: assert property (p_led_speed) else $error("indicator dark at speed");
endmodule

// *** testbench/lmdp_link_model.sv ***
// link handler model on the far side of the link port
`timescale 1ns/1ps
module lmdp_link_model (
    // clock
    input  wire logic        i_sys_clk,
    // from the data path
    input  wire logic        i_ready,
    input  wire logic        i_valid,
    input  wire logic [7:0]  i_data,
    input  wire logic        i_last,
    input  wire logic [15:0] i_crc,
    // to the data path
    output logic             o_valid,
    output logic [7:0]       o_data,
    output logic             o_last,
    output logic [15:0]      o_crc,
    output logic             o_rd
);
    logic [15:0] rx_crc = lmdp_pkg::CRC_INIT;
    logic        crc_ok = 1'h0;
    logic [7:0]  got[$];
    initial o_valid = 1'h0;
    initial o_last = 1'h0;
    initial o_rd = 1'h0;
    // bitwise check update, msb first
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        for (int k = 7; k >= 0; k--)
            c = {c[14:0], 1'h0} ^ ((c[15] ^ d[k]) ? lmdp_pkg::CRC_POLY : 16'h0000);
        return c;
    endfunction
    // send bytes 0..n-1 and append the check; bad corrupts it
    task automatic send(input int n, input logic bad);
        logic [15:0] c;
        c = lmdp_pkg::CRC_INIT;
        for (int i = 0; i < n; i++) begin
            c = crc_step(c, i[7:0]);
            o_valid = 1'h1;
            o_data = i[7:0];
            o_last = (i == n - 1);
            o_crc = bad ? ~c : c;
            @(posedge i_sys_clk);
            while (!i_ready)
                @(posedge i_sys_clk);
            #1;
        end
        o_valid = 1'h0;
        o_last = 1'h0;
        o_data = ~o_data;
        o_crc = ~o_crc;
    endtask
    // request n bytes back to back
    task automatic pull(input int n);
        o_rd = 1'h1;
        repeat (n) @(posedge i_sys_clk);
        #1;
        o_rd = 1'h0;
    endtask
    // collect bytes and verify the check at frame end
    always @(posedge i_sys_clk) begin
        if (i_valid) begin
            got.push_back(i_data);
            rx_crc = crc_step(rx_crc, i_data);
            if (i_last) begin
                crc_ok = (rx_crc === i_crc);
                rx_crc = lmdp_pkg::CRC_INIT;
            end
        end
    end
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the load module data path
`timescale 1ns/1ps
module tb;
    logic i_sys_clk = 0, i_sys_rst = 1, i_scsi_dma = 0, i_scsi_rd = 0, i_scsi_wr = 0;
    logic i_scsi_par = 0, i_cpu_isolate = 0, i_cpu_test = 0, i_cpu_wr = 0, i_cpu_rd = 0;
    logic i_pwr_switch = 0, i_pwr_ctrl = 0, i_link_valid, i_link_last, i_link_rd;
    logic o_link_ready, o_link_valid, o_link_last, o_scsi_valid, o_scsi_par, o_cpu_valid;
    logic o_bus_isolated, o_cpu_bus_en, o_tx_empty, o_rx_full, o_conv_en, o_led;
    logic [7:0]  i_link_data, o_link_data, o_scsi_data, o_cpu_data;
    logic [7:0]  i_scsi_data = 8'h00, i_cpu_data = 8'h00;
    logic [15:0] i_link_crc, o_link_crc;
    logic [3:0]  i_err_clr = 4'h0, o_err;
    logic [2:0]  i_disk_state = 3'h1;
    int          bad_count = 0, n_checks = 0, cyc = 0;
    // design and link partner
    lmdp_data_path i_lmdp_data_path (.*);
    lmdp_link_model i_lmdp_link_model (.i_sys_clk, .i_ready(o_link_ready),
        .i_valid(o_link_valid), .i_data(o_link_data), .i_last(o_link_last), .i_crc(o_link_crc),
        .o_valid(i_link_valid), .o_data(i_link_data), .o_last(i_link_last), .o_crc(i_link_crc),
        .o_rd(i_link_rd));
    // clock and hang guard
    always #12.5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    // write bytes 0..n-1 by test port or scsi dma
    task automatic push(input int n, input logic cpu);
        for (int i = 0; i < n; i++) begin
            i_cpu_data = i[7:0];
            i_scsi_data = i[7:0];
            i_scsi_par = ~^i[7:0];
            i_cpu_wr = cpu;
            i_scsi_wr = !cpu;
            step(1);
        end
        i_cpu_wr = 1'h0;
        i_scsi_wr = 1'h0;
    endtask
    // read n bytes back to back and compare with 0..n-1
    task automatic pop(input int n, input logic cpu);
        i_cpu_rd = cpu;
        i_scsi_rd = !cpu;
        for (int i = 0; i < n; i++) begin
            step(1);
            if (i == n - 1) begin
                i_cpu_rd = 1'h0;
                i_scsi_rd = 1'h0;
            end
            if (cpu)
                chk({o_cpu_valid, o_cpu_data}, {1'h1, i[7:0]});
            else
                chk({o_scsi_valid, o_scsi_data, o_scsi_par}, {1'h1, i[7:0], ~^i[7:0]});
        end
    endtask
    task automatic t_tx_path();
        i_scsi_dma = 1'h1;
        i_lmdp_link_model.send(5, 1'h0);
        pop(5, 1'h0);
        step(1);
        chk({o_tx_empty, o_err}, 16'h0010);
        i_lmdp_link_model.send(3, 1'h1);
        pop(3, 1'h0);
        chk(o_err, 16'h0008);
        i_err_clr = 4'h8;
        step(1);
        i_err_clr = 4'h0;
        step(1);
        chk(o_err, 16'h0000);
    endtask
    task automatic t_fill();
        i_scsi_dma = 1'h0;
        i_cpu_test = 1'h1;
        step(1);
        push(2049, 1'h1);
        i_cpu_test = 1'h0;
        step(2);
        chk({o_link_ready, o_tx_empty}, 16'h0000);
        i_scsi_dma = 1'h1;
        pop(2048, 1'h0);
        step(1);
        chk(o_tx_empty, 16'h0001);
    endtask
    task automatic t_rx_path();
        push(2048, 1'h0);
        step(1);
        chk(o_rx_full, 16'h0001);
        i_scsi_dma = 1'h0;
        i_cpu_test = 1'h1;
        step(1);
        pop(2048, 1'h1);
        i_cpu_test = 1'h0;
        i_scsi_dma = 1'h1;
        push(4, 1'h0);
        i_lmdp_link_model.pull(4);
        step(2);
        chk(16'(i_lmdp_link_model.got.size()), 16'h0004);
        chk(i_lmdp_link_model.got[3], 16'h0003);
        chk(i_lmdp_link_model.crc_ok, 16'h0001);
        i_scsi_data = 8'h5A;
        i_scsi_par = 1'h0;
        i_scsi_wr = 1'h1;
        step(1);
        i_scsi_wr = 1'h0;
        step(1);
        chk(o_err, 16'h0004);
    endtask
    task automatic t_iso();
        i_scsi_dma = 1'h0;
        step(1);
        chk({o_bus_isolated, o_cpu_bus_en}, 16'h0001);
        i_cpu_isolate = 1'h1;
        step(1);
        chk({o_bus_isolated, o_cpu_bus_en}, 16'h0002);
        i_cpu_isolate = 1'h0;
        i_scsi_dma = 1'h1;
        step(1);
        chk({o_bus_isolated, o_cpu_bus_en}, 16'h0002);
    endtask
    task automatic t_power();
        // control held on while the processor runs
        i_pwr_ctrl = 1'h1;
        i_pwr_switch = 1'h1;
        step(5);
        chk(o_conv_en, 16'h0001);
        i_pwr_switch = 1'h0;
        step(5);
        chk(o_conv_en, 16'h0001);
        i_pwr_ctrl = 1'h0;
        step(1);
        chk(o_conv_en, 16'h0000);
        i_pwr_ctrl = 1'h1;
        step(5);
        chk(o_conv_en, 16'h0000);
        i_pwr_ctrl = 1'h0;
        i_pwr_switch = 1'h1;
        step(5);
        chk(o_conv_en, 16'h0000);
        i_disk_state = 3'h4;
        step(2);
        chk(o_led, 16'h0001);
        // flash half period outlasts the run, so spinning shows the dark phase
        i_disk_state = 3'h2;
        step(2);
        chk(o_led, 16'h0000);
        i_disk_state = 3'h1;
        step(2);
        chk(o_led, 16'h0000);
    endtask
    // reset, then the scenarios
    initial begin
        repeat (15) @(posedge i_sys_clk);
        chk({o_bus_isolated, o_link_ready, o_tx_empty, o_err, o_conv_en}, 16'h00E0);
        step(1);
        i_sys_rst = 1'h0;
        t_tx_path();
        t_fill();
        t_rx_path();
        t_iso();
        t_power();
        stop_test();
    end
endmodule
bind lmdp_data_path lmdp_data_path_chk i_lmdp_data_path_chk (.*);
